// ===== shared/pfs_pkg.sv
// Shared constants and types of the program flow sequencer
package pfs_pkg;

  // Instruction and address widths
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned MAX_ADDR_W  = 12;
  localparam int unsigned MIN_ADDR_W  = 10;
  localparam int unsigned PAGE_W      = 11;   // 2K steps per page
  localparam int unsigned STACK_DEPTH = 5;
  localparam int unsigned VEC_W       = 3;

  // Reset and interrupt vectors
  localparam logic [MAX_ADDR_W-1:0] VEC_RESET  = 12'h000;
  localparam logic [MAX_ADDR_W-1:0] VEC_SERIAL = 12'h001;
  localparam logic [MAX_ADDR_W-1:0] VEC_BASIC  = 12'h002;
  localparam logic [MAX_ADDR_W-1:0] VEC_TIMER1 = 12'h003;
  localparam logic [MAX_ADDR_W-1:0] VEC_TIMER0 = 12'h004;
  localparam logic [MAX_ADDR_W-1:0] VEC_EXTPIN = 12'h005;

  // Interrupt source codes on the request port
  localparam logic [VEC_W-1:0] SRC_SERIAL = 3'h1;
  localparam logic [VEC_W-1:0] SRC_BASIC  = 3'h2;
  localparam logic [VEC_W-1:0] SRC_TIMER1 = 3'h3;
  localparam logic [VEC_W-1:0] SRC_TIMER0 = 3'h4;
  localparam logic [VEC_W-1:0] SRC_EXTPIN = 3'h5;

  // Opcode fields: direct jump page 0 / page 1 and direct call
  localparam int unsigned   OPC_LSB      = 11;
  localparam int unsigned   PAGE_SEL_BIT = 12;
  localparam logic [4:0]    OPC_JMP_P0   = 5'h18;  // 0C000H..0C7FFH
  localparam logic [4:0]    OPC_JMP_P1   = 5'h1A;  // 0D000H..0D7FFH
  localparam logic [4:0]    OPC_CALL_DIR = 5'h1D;  // 0E800H..0EFFFH

  // Whole-word opcodes of the operand-free flow instructions
  localparam logic [WORD_W-1:0] OPW_JMP_IND  = 16'h00F1;
  localparam logic [WORD_W-1:0] OPW_CALL_IND = 16'h00F2;
  localparam logic [WORD_W-1:0] OPW_RET      = 16'h00F3;
  localparam logic [WORD_W-1:0] OPW_RET_SKIP = 16'h00F4;
  localparam logic [WORD_W-1:0] OPW_TBL_READ = 16'h00F5;

  // Instruction classes seen by the sequencer
  typedef enum logic [2:0] {
    PFS_CLS_OTHER, PFS_CLS_JMP_DIR, PFS_CLS_JMP_IND, PFS_CLS_CALL_DIR,
    PFS_CLS_CALL_IND, PFS_CLS_RET, PFS_CLS_RET_SKIP, PFS_CLS_TBL
  } pfs_class_e;

endpackage

// ===== shared/pfs_stack_if.sv
// Interface between the sequencer and its address stack
`timescale 1ns/1ps
interface pfs_stack_if #(parameter int unsigned ADDR_W = 12);
  logic              push;
  logic              pop;
  logic [ADDR_W-1:0] wdata;
  logic [ADDR_W-1:0] rdata;
  logic              empty;
  logic              full;

  modport seq (output push, output pop, output wdata,
               input rdata, input empty, input full);
  modport stk (input push, input pop, input wdata,
               output rdata, output empty, output full);
endinterface

// ===== rtl/pfs_addr_stack.sv
// Return address stack of the program flow sequencer
`timescale 1ns/1ps
module pfs_addr_stack #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned DEPTH  = pfs_pkg::STACK_DEPTH
) (
  // Clock, enable and reset
  input  wire logic  clk_in,
  input  wire logic  ce_in,
  input  wire logic  rst_n_in,
  // Stack port
  pfs_stack_if.stk   stk
);

  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  logic [ADDR_W-1:0] mem [DEPTH];
  logic [CNT_W-1:0]  level;

  // Refuse a stack too shallow to nest anything
  initial begin
    if (DEPTH < 2) $error("pfs_addr_stack: DEPTH below 2");
  end

  // Fill level; push on full and pop on empty are ignored
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level <= '0;
    end else if (ce_in) begin
      if (stk.push && !stk.full) begin
        level <= level + CNT_W'(1);
      end else if (stk.pop && !stk.empty) begin
        level <= level - CNT_W'(1);
      end
    end
  end

  // Entry storage
  always_ff @(posedge clk_in) begin
    if (ce_in && stk.push && !stk.full) begin
      mem[level] <= stk.wdata;
    end
  end

  // Top of stack and status
  assign stk.empty = (level == '0);
  assign stk.full  = (level == CNT_W'(DEPTH));
  assign stk.rdata = stk.empty ? '0 : mem[level - CNT_W'(1)];

endmodule // pfs_addr_stack

// ===== rtl/pfs_decode.sv
// Instruction class decoder of the program flow sequencer
`timescale 1ns/1ps
module pfs_decode (
  // Fetched instruction word
  input  wire logic [pfs_pkg::WORD_W-1:0] word_in,
  // Decoded class
  output pfs_pkg::pfs_class_e             class_out
);

  logic [4:0] opc;

  assign opc = word_in[pfs_pkg::WORD_W-1:pfs_pkg::OPC_LSB];

  // Classify the word; anything else is left to the data path
  always_comb begin
    class_out = pfs_pkg::PFS_CLS_OTHER;
    if (opc == pfs_pkg::OPC_JMP_P0 || opc == pfs_pkg::OPC_JMP_P1) begin
      class_out = pfs_pkg::PFS_CLS_JMP_DIR;
    end else if (opc == pfs_pkg::OPC_CALL_DIR) begin
      class_out = pfs_pkg::PFS_CLS_CALL_DIR;
    end else if (word_in == pfs_pkg::OPW_JMP_IND) begin
      class_out = pfs_pkg::PFS_CLS_JMP_IND;
    end else if (word_in == pfs_pkg::OPW_CALL_IND) begin
      class_out = pfs_pkg::PFS_CLS_CALL_IND;
    end else if (word_in == pfs_pkg::OPW_RET) begin
      class_out = pfs_pkg::PFS_CLS_RET;
    end else if (word_in == pfs_pkg::OPW_RET_SKIP) begin
      class_out = pfs_pkg::PFS_CLS_RET_SKIP;
    end else if (word_in == pfs_pkg::OPW_TBL_READ) begin
      class_out = pfs_pkg::PFS_CLS_TBL;
    end
  end

endmodule // pfs_decode

// ===== rtl/pfs_sequencer.sv
// Program flow sequencer: fetch address, branches, calls, returns, table read
`timescale 1ns/1ps
module pfs_sequencer #(
  parameter int unsigned ADDR_W      = pfs_pkg::MAX_ADDR_W,
  parameter int unsigned STACK_DEPTH = pfs_pkg::STACK_DEPTH
) (
  // Clock, reset and enable
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       ce_in,
  // Program memory read port
  output logic [ADDR_W-1:0]               rom_addr_out,
  output logic                            rom_rd_out,
  input  wire logic [pfs_pkg::WORD_W-1:0] rom_data_in,
  // Core data path
  input  wire logic [ADDR_W-1:0]          indirect_address_register_in,
  input  wire logic                       skip_in,
  output logic [pfs_pkg::WORD_W-1:0]      exec_word_out,
  output logic                            exec_valid_out,
  output logic                            exec_nop_out,
  // Table read result
  output logic [pfs_pkg::WORD_W-1:0]      data_buffer_word_out,
  output logic                            table_done_out,
  // Interrupt acceptance
  input  wire logic                       irq_req_in,
  input  wire logic [pfs_pkg::VEC_W-1:0]  irq_source_in,
  output logic                            irq_ack_out,
  // Stack misuse
  output logic                            stack_fault_out
);

  typedef enum logic {PFS_ST_EXEC, PFS_ST_TBL} pfs_state_e;

  // Refuse address widths that no memory variant has
  initial begin
    if (ADDR_W < pfs_pkg::MIN_ADDR_W || ADDR_W > pfs_pkg::MAX_ADDR_W) begin
      $error("pfs_sequencer: ADDR_W must be 10, 11 or 12");
    end
  end

  // Builds the direct jump target for this memory size
  function automatic logic [ADDR_W-1:0] jump_target(input logic [pfs_pkg::WORD_W-1:0] w);
    logic [pfs_pkg::MAX_ADDR_W-1:0] full;
    full = {w[pfs_pkg::PAGE_SEL_BIT], w[pfs_pkg::PAGE_W-1:0]};
    return full[ADDR_W-1:0];
  endfunction

  // Builds a page 0 target from an 11-bit operand
  function automatic logic [ADDR_W-1:0] page0_target(input logic [pfs_pkg::WORD_W-1:0] w);
    logic [pfs_pkg::MAX_ADDR_W-1:0] full;
    full = {1'b0, w[pfs_pkg::PAGE_W-1:0]};
    return full[ADDR_W-1:0];
  endfunction

  // Maps an interrupt source to its vector; zero means no valid source
  function automatic logic [pfs_pkg::MAX_ADDR_W-1:0] vector_of(
      input logic [pfs_pkg::VEC_W-1:0] src);
    unique case (src)
      pfs_pkg::SRC_SERIAL: vector_of = pfs_pkg::VEC_SERIAL;
      pfs_pkg::SRC_BASIC:  vector_of = pfs_pkg::VEC_BASIC;
      pfs_pkg::SRC_TIMER1: vector_of = pfs_pkg::VEC_TIMER1;
      pfs_pkg::SRC_TIMER0: vector_of = pfs_pkg::VEC_TIMER0;
      pfs_pkg::SRC_EXTPIN: vector_of = pfs_pkg::VEC_EXTPIN;
      default:             vector_of = pfs_pkg::VEC_RESET;
    endcase
  endfunction

  logic                           rst_meta;
  logic                           rst_n;
  logic [ADDR_W-1:0]              pc;
  logic [ADDR_W-1:0]              next_pc;
  logic [ADDR_W-1:0]              pc_plus1;
  pfs_state_e                     state;
  pfs_state_e                     next_state;
  logic                           skip_pend;
  logic                           next_skip;
  logic                           irq_take;
  logic                           vec_ok;
  logic                           executes;
  logic                           fault_now;
  logic [pfs_pkg::MAX_ADDR_W-1:0] vec_full;
  pfs_pkg::pfs_class_e            cls;

  pfs_stack_if #(.ADDR_W(ADDR_W)) stk_bus ();

  // Reset release through two flip-flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Instruction class of the word now on the memory data input
  pfs_decode u_decode (
    .word_in   (rom_data_in),
    .class_out (cls)
  );

  // Return address stack
  pfs_addr_stack #(
    .ADDR_W (ADDR_W),
    .DEPTH  (STACK_DEPTH)
  ) u_stack (
    .clk_in   (clk_in),
    .ce_in    (ce_in),
    .rst_n_in (rst_n),
    .stk      (stk_bus.stk)
  );

  assign pc_plus1 = pc + ADDR_W'(1);
  assign vec_full = vector_of(irq_source_in);
  assign vec_ok   = (irq_source_in >= pfs_pkg::SRC_SERIAL) &&
                    (irq_source_in <= pfs_pkg::SRC_EXTPIN);

  // Interrupts enter only between instructions, never on a skipped slot
  assign irq_take = rst_n && ce_in && irq_req_in && vec_ok &&
                    (state == PFS_ST_EXEC) && !skip_pend;
  assign irq_ack_out = irq_take;

  // The fetched word takes its execute slot in this cycle, as a no-op when a skip is pending
  assign executes = (state == PFS_ST_EXEC) && !irq_take;

  // Next fetch address, stack traffic and state
  always_comb begin
    next_pc            = pc_plus1;
    next_state         = PFS_ST_EXEC;
    next_skip          = 1'b0;
    stk_bus.push       = 1'b0;
    stk_bus.pop        = 1'b0;
    stk_bus.wdata      = pc_plus1;
    if (state == PFS_ST_TBL) begin
      // Second cycle: free the level and go back past the table read
      stk_bus.pop = 1'b1;
      next_pc     = stk_bus.rdata;
    end else if (irq_take) begin
      // The interrupted instruction runs again after the return
      stk_bus.push  = 1'b1;
      stk_bus.wdata = pc;
      next_pc       = vec_full[ADDR_W-1:0];
    end else if (skip_pend) begin
      next_pc = pc_plus1;
    end else begin
      next_skip = skip_in && (cls == pfs_pkg::PFS_CLS_OTHER);
      unique case (cls)
        pfs_pkg::PFS_CLS_JMP_DIR: begin
          next_pc = jump_target(rom_data_in);
        end
        pfs_pkg::PFS_CLS_JMP_IND: begin
          next_pc = indirect_address_register_in;
        end
        pfs_pkg::PFS_CLS_CALL_DIR: begin
          stk_bus.push = 1'b1;
          next_pc      = page0_target(rom_data_in);
        end
        pfs_pkg::PFS_CLS_CALL_IND: begin
          stk_bus.push = 1'b1;
          next_pc      = indirect_address_register_in;
        end
        pfs_pkg::PFS_CLS_RET: begin
          stk_bus.pop = 1'b1;
          next_pc     = stk_bus.rdata;
        end
        pfs_pkg::PFS_CLS_RET_SKIP: begin
          stk_bus.pop = 1'b1;
          next_pc     = stk_bus.rdata;
          next_skip   = 1'b1;
        end
        pfs_pkg::PFS_CLS_TBL: begin
          // First cycle: hold the return point, fetch the table word
          stk_bus.push = 1'b1;
          next_pc      = indirect_address_register_in;
          next_state   = PFS_ST_TBL;
        end
        pfs_pkg::PFS_CLS_OTHER: begin
          next_pc = pc_plus1;
        end
      endcase
    end
  end

  // A push into a full stack or a pop from an empty one
  assign fault_now = (stk_bus.push && stk_bus.full) || (stk_bus.pop && stk_bus.empty);

  // Program counter, the fetch address; starts at the reset vector
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pc <= pfs_pkg::VEC_RESET[ADDR_W-1:0];
    end else if (ce_in) begin
      pc <= next_pc;
    end
  end

  // Sequencing state and pending skip
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state     <= PFS_ST_EXEC;
      skip_pend <= 1'b0;
    end else if (ce_in) begin
      state     <= next_state;
      skip_pend <= next_skip;
    end
  end

  // Executed word reported to the data path one cycle later
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      exec_word_out  <= 16'h0000;
      exec_valid_out <= 1'b0;
      exec_nop_out   <= 1'b0;
    end else if (ce_in) begin
      exec_word_out  <= rom_data_in;
      exec_valid_out <= executes;
      exec_nop_out   <= executes && skip_pend;
    end
  end

  // Table word captured in the second cycle of the table read
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      data_buffer_word_out <= 16'h0000;
      table_done_out       <= 1'b0;
    end else if (ce_in) begin
      table_done_out <= (state == PFS_ST_TBL);
      if (state == PFS_ST_TBL) begin
        data_buffer_word_out <= rom_data_in;
      end
    end
  end

  // Stack misuse pulse
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      stack_fault_out <= 1'b0;
    end else if (ce_in) begin
      stack_fault_out <= fault_now;
    end
  end

  // Memory port: read only, one word per address
  assign rom_addr_out = pc;
  assign rom_rd_out   = rst_n && ce_in;

endmodule // pfs_sequencer

// ===== tb/pfs_rom_model.sv
// Behavioural read-only program memory that answers the sequencer's fetches
`timescale 1ns/1ps
module pfs_rom_model #(
  parameter int unsigned ADDR_W = 12
) (
  // Fetch port
  input  wire logic [ADDR_W-1:0]          addr_in,
  input  wire logic                       rd_in,
  output logic [pfs_pkg::WORD_W-1:0]      data_out
);
  logic [pfs_pkg::WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Blank image, filled by the bench before reset ends
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      mem[i] = 16'h0000;
    end
  end

  // One whole word per address and no write path; unselected reads show no stale word
  always_comb begin
    if (rd_in) begin
      data_out = mem[addr_in];
    end else begin
      data_out = ~mem[addr_in];
    end
  end
endmodule // pfs_rom_model

// ===== tb/pfs_sequencer_assertions.sv
// Port-level timing checks of the program flow sequencer
`timescale 1ns/1ps
module pfs_sequencer_assertions #(
  parameter int unsigned ADDR_W = 12
) (
  // Watched ports
  input wire logic                       clk_in,
  input wire logic                       rst_n_in,
  input wire logic                       ce_in,
  input wire logic [ADDR_W-1:0]          rom_addr_out,
  input wire logic                       rom_rd_out,
  input wire logic [pfs_pkg::WORD_W-1:0] rom_data_in,
  input wire logic [ADDR_W-1:0]          indirect_address_register_in,
  input wire logic [pfs_pkg::WORD_W-1:0] exec_word_out,
  input wire logic                       exec_valid_out,
  input wire logic                       exec_nop_out,
  input wire logic [pfs_pkg::WORD_W-1:0] data_buffer_word_out,
  input wire logic                       table_done_out,
  input wire logic                       irq_req_in,
  input wire logic [pfs_pkg::VEC_W-1:0]  irq_source_in,
  input wire logic                       irq_ack_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic ce_q;
  logic started;
  logic run;
  // Enable of the last edge and first-fetch marker
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ce_q    <= 1'b0;
      started <= 1'b0;
    end else begin
      ce_q    <= ce_in;
      started <= started | rom_rd_out;
    end
  end
  assign run = ce_q && exec_valid_out && !exec_nop_out;

  // Flow-changing opcodes
  function automatic logic is_flow(input logic [15:0] w);
    return w[15:11] == pfs_pkg::OPC_JMP_P0 || w[15:11] == pfs_pkg::OPC_JMP_P1
        || w[15:11] == pfs_pkg::OPC_CALL_DIR || (w >= 16'h00F1 && w <= 16'h00F5);
  endfunction

  // Vector expected for each interrupt source code
  function automatic logic [pfs_pkg::MAX_ADDR_W-1:0] vec_exp(input logic [2:0] s);
    unique case (s)
      pfs_pkg::SRC_SERIAL: return pfs_pkg::VEC_SERIAL;
      pfs_pkg::SRC_BASIC:  return pfs_pkg::VEC_BASIC;
      pfs_pkg::SRC_TIMER1: return pfs_pkg::VEC_TIMER1;
      pfs_pkg::SRC_TIMER0: return pfs_pkg::VEC_TIMER0;
      pfs_pkg::SRC_EXTPIN: return pfs_pkg::VEC_EXTPIN;
      default:             return pfs_pkg::VEC_RESET;
    endcase
  endfunction

  sequence s_tbl_issue;
    run && exec_word_out == pfs_pkg::OPW_TBL_READ;
  endsequence
  sequence s_tbl_land;
    ce_q && !exec_valid_out && table_done_out && data_buffer_word_out == $past(rom_data_in);
  endsequence

  a_reset_vector: assert property (
    rom_rd_out && !started |-> rom_addr_out == '0) else $error("First fetch not at zero");
  a_step_next: assert property (
    ce_q && exec_valid_out && (exec_nop_out || !is_flow(exec_word_out))
    |-> rom_addr_out == ADDR_W'($past(rom_addr_out) + 1)) else $error("Fetch did not step by one");
  a_jump_target: assert property (
    run && (exec_word_out[15:11] == pfs_pkg::OPC_JMP_P0
         || exec_word_out[15:11] == pfs_pkg::OPC_JMP_P1)
    |-> rom_addr_out == ADDR_W'({exec_word_out[12], exec_word_out[10:0]}))
    else $error("Direct jump target wrong");
  a_call_page0: assert property (
    run && exec_word_out[15:11] == pfs_pkg::OPC_CALL_DIR
    |-> rom_addr_out == ADDR_W'({1'b0, exec_word_out[10:0]})) else $error("Direct call target wrong");
  a_indirect_target: assert property (
    run && (exec_word_out == pfs_pkg::OPW_JMP_IND || exec_word_out == pfs_pkg::OPW_CALL_IND)
    |-> rom_addr_out == $past(indirect_address_register_in)) else $error("Indirect target wrong");
  a_table_addr: assert property (
    s_tbl_issue |-> rom_addr_out == $past(indirect_address_register_in))
    else $error("Table read address wrong");
  a_table_done: assert property (
    s_tbl_issue |=> s_tbl_land) else $error("Table read result wrong");
  a_table_resume: assert property (
    s_tbl_issue ##1 ce_q |-> rom_addr_out == ADDR_W'($past(rom_addr_out, 2) + 1))
    else $error("Fetch after table read wrong");
  a_irq_vector: assert property (
    irq_ack_out && ce_in |=> !exec_valid_out && rom_addr_out == ADDR_W'(vec_exp($past(irq_source_in))))
    else $error("Interrupt vector wrong");
  a_irq_refused: assert property (
    irq_req_in && (irq_source_in == 3'h0 || irq_source_in > 3'h5) |-> !irq_ack_out)
    else $error("Invalid interrupt source taken");
endmodule // pfs_sequencer_assertions

bind pfs_sequencer pfs_sequencer_assertions #(.ADDR_W(ADDR_W)) i_pfs_sequencer_assertions (
  .clk_in, .rst_n_in, .ce_in, .rom_addr_out, .rom_rd_out, .rom_data_in,
  .indirect_address_register_in, .exec_word_out, .exec_valid_out, .exec_nop_out,
  .data_buffer_word_out, .table_done_out, .irq_req_in, .irq_source_in, .irq_ack_out);

// ===== tb/program_flow_sequencer_test.sv
// Self-checking bench of the program flow sequencer
`timescale 1ns/1ps
module program_flow_sequencer_test;
  localparam int unsigned AW = pfs_pkg::MAX_ADDR_W;
  // Program image: address in bits 27:16, word in bits 15:0
  localparam logic [27:0] IMG [0:20] = '{
    28'h000C040, 28'h041D005, 28'h805C010, 28'h010E820, 28'h02000F2, 28'hABC00F5,
    28'h7F01234, 28'hABD00F3, 28'h02100F4, 28'h01100F1, 28'h01200F1, 28'h00100F3,
    28'h00200F3, 28'h00300F3, 28'h00400F3, 28'h00500F3, 28'h30300F3, 28'h0400000,
    28'h3000000, 28'h3010000, 28'h3020000};
  // Design signals and counters
  logic                       clk_in = 1'b0;
  logic                       rst_n_in = 1'b0;
  logic                       ce_in = 1'b1;
  logic [AW-1:0]              rom_addr_out;
  logic                       rom_rd_out;
  logic [pfs_pkg::WORD_W-1:0] rom_data_in;
  logic [AW-1:0]              indirect_address_register_in = '0;
  logic                       skip_in = 1'b0;
  logic [pfs_pkg::WORD_W-1:0] exec_word_out;
  logic                       exec_valid_out;
  logic                       exec_nop_out;
  logic [pfs_pkg::WORD_W-1:0] data_buffer_word_out;
  logic                       table_done_out;
  logic                       irq_req_in = 1'b0;
  logic [pfs_pkg::VEC_W-1:0]  irq_source_in = '0;
  logic                       irq_ack_out;
  logic                       stack_fault_out;
  int                         miscompares = 0;
  int                         check_count = 0;
  int                         cycles = 0;

  pfs_sequencer #(.ADDR_W(AW)) i_pfs_sequencer (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .rom_addr_out(rom_addr_out),
    .rom_rd_out(rom_rd_out), .rom_data_in(rom_data_in),
    .indirect_address_register_in(indirect_address_register_in), .skip_in(skip_in),
    .exec_word_out(exec_word_out), .exec_valid_out(exec_valid_out),
    .exec_nop_out(exec_nop_out), .data_buffer_word_out(data_buffer_word_out),
    .table_done_out(table_done_out), .irq_req_in(irq_req_in),
    .irq_source_in(irq_source_in), .irq_ack_out(irq_ack_out),
    .stack_fault_out(stack_fault_out));
  pfs_rom_model #(.ADDR_W(AW)) i_pfs_rom_model (
    .addr_in(rom_addr_out), .rd_in(rom_rd_out), .data_out(rom_data_in));

  // 250 MHz clock
  always #2 clk_in = ~clk_in;

  // Cut a hung run short
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 500) begin
      miscompares++;
      complete_run();
    end
  end

  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Let one fetch edge pass, then check the new fetch address
  task automatic cyc(input logic [AW-1:0] exp);
    @(posedge clk_in);
    #1;
    check("fetch address", 16'(rom_addr_out), 16'(exp));
  endtask

  task automatic t_reset_and_jumps();
    repeat (12) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    for (int i = 0; i < 8 && rom_rd_out !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    check("reset address", 16'(rom_addr_out), 16'h0000);
    cyc(12'h040);
    cyc(12'h041);
    cyc(12'h805);
    check("executed word", exec_word_out, 16'hD005);
    cyc(12'h010);
  endtask

  task automatic t_calls_and_table();
    cyc(12'h020);
    indirect_address_register_in = 12'hABC;
    cyc(12'hABC);
    indirect_address_register_in = 12'h7F0;
    cyc(12'h7F0);
    indirect_address_register_in = 12'h555;
    cyc(12'hABD);
    check("slot valid", 16'(exec_valid_out), 16'h0000);
    check("table done", 16'(table_done_out), 16'h0001);
    check("data buffer", data_buffer_word_out, 16'h1234);
    cyc(12'h021);
    cyc(12'h011);
    cyc(12'h012);
    check("skipped slot", 16'(exec_nop_out), 16'h0001);
    indirect_address_register_in = 12'h300;
    cyc(12'h300);
  endtask

  task automatic t_skip_slot();
    skip_in = 1'b1;
    cyc(12'h301);
    skip_in = 1'b0;
    cyc(12'h302);
    check("skipped slot", 16'(exec_nop_out), 16'h0001);
  endtask

  task automatic t_interrupts();
    for (int s = 1; s <= 5; s++) begin
      irq_req_in = 1'b1;
      irq_source_in = 3'(s);
      @(negedge clk_in);
      check("interrupt taken", 16'(irq_ack_out), 16'h0001);
      cyc(AW'(s));
      irq_req_in = 1'b0;
      check("slot valid", 16'(exec_valid_out), 16'h0000);
      cyc(12'h302);
    end
    irq_req_in = 1'b1;
    irq_source_in = 3'h0;
    @(negedge clk_in);
    check("interrupt taken", 16'(irq_ack_out), 16'h0000);
    cyc(12'h303);
    irq_req_in = 1'b0;
  endtask

  task automatic t_stack_empty();
    logic seen;
    cyc(12'h000);
    seen = stack_fault_out;
    cyc(12'h040);
    seen = seen | stack_fault_out;
    check("stack fault", 16'(seen), 16'h0001);
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    #1;
    for (int i = 0; i < 21; i++) begin
      i_pfs_rom_model.mem[IMG[i][27:16]] = IMG[i][15:0];
    end
    t_reset_and_jumps();
    t_calls_and_table();
    t_skip_slot();
    t_interrupts();
    t_stack_empty();
    complete_run();
  end
endmodule // program_flow_sequencer_test
